// ===== logic/sync_arm_regs.svh
// Register offsets, fields, reset values and timing counts of the sequencer
`ifndef SYNC_ARM_REGS_SVH
`define SYNC_ARM_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define SA_CTRL_OFF 8'h00
`define SA_SYNC_OFF 8'h04
`define SA_INIT_OFF 8'h08
`define SA_CHECK_OFF 8'h0c
`define SA_STATUS_OFF 8'h10
`define SA_STOP_OFF 8'h14
`define SA_ADDR_OFF 8'h18
`define SA_DLY_OFF 8'h1c
// ==========================================================
// Field positions
`define SA_CTRL_LEVEL_BIT 0
`define SA_CTRL_TTL_LSB 4
`define SA_CTRL_TTL_MSB 7
`define SA_INIT_GRP_LSB 0
`define SA_INIT_GRP_MSB 3
`define SA_INIT_MODE_LSB 4
`define SA_INIT_MODE_MSB 5
`define SA_INIT_ZERO_LSB 8
`define SA_INIT_ZERO_MSB 11
`define SA_INIT_EXTARM_BIT 12
// ==========================================================
// Reset values
`define SA_LEVEL_RST 1'b0
`define SA_TTL_RST 4'h8
`define SA_TTL_OFF 4'h8
`define SA_GRP_DEFAULT 4'h1
// ==========================================================
// Timing: 16 ms settle and delay step at 50 MHz
`define SA_STEP_MS 16
`define SA_CLK_KHZ 50000
`define SA_STEP_CYC (`SA_STEP_MS * `SA_CLK_KHZ)

`endif

// ===== logic/sync_arm_pkg.sv
// Types shared by the sync and arm sequencer
package sync_arm_pkg;
  // Initiate flavours
  typedef enum logic [1:0] {
    MODE_IMM = 2'h0,
    MODE_DELAY = 2'h1,
    MODE_CONT = 2'h2
  } init_mode_e;
  // Arming sequence states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_CHECK = 10'h002,
    ST_RANGE = 10'h004,
    ST_ZERO = 10'h008,
    ST_LOAD = 10'h010,
    ST_SETUP = 10'h020,
    ST_CLRMC = 10'h040,
    ST_ENABLE = 10'h080,
    ST_DELAY = 10'h100,
    ST_ARMTRG = 10'h200
  } arm_state_e;
  typedef logic [3:0] grp_t;
endpackage

// ===== logic/level_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
  parameter int W = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } state_s;
  state_s st_q;
  state_s st_d;

  // First stage feeds only the second
  always_comb begin
    st_d = st_q;
    st_d.meta = i_async;
    st_d.sync = st_q.meta;
  end

  // Registered with synchronous reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign o_sync = st_q.sync;
endmodule
`default_nettype wire

// ===== logic/step_timer.sv
// Countdown timer in whole 16 ms steps, with done pulse
`timescale 1ns/1ns
`default_nettype none
`include "sync_arm_regs.svh"
module step_timer #(
  parameter int STEP_CYC = `SA_STEP_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [31:0] i_steps,
  output logic o_busy,
  output logic o_done
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] steps;
    logic [31:0] cyc;
    logic busy;
    logic done;
  } state_s;
  state_s st_q;
  state_s st_d;

  // Count cycles within a step, then steps
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (i_start) begin
      // Zero steps finishes at once
      st_d.busy = (i_steps != 32'h0);
      st_d.done = (i_steps == 32'h0);
      st_d.steps = i_steps;
      st_d.cyc = 32'(STEP_CYC - 1);
    end else if (st_q.busy) begin
      if (st_q.cyc != 32'h0) begin
        st_d.cyc = st_q.cyc - 32'h1;
      end else if (st_q.steps == 32'h1) begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end else begin
        st_d.steps = st_q.steps - 32'h1;
        st_d.cyc = 32'(STEP_CYC - 1);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign o_busy = st_q.busy;
  assign o_done = st_q.done;
endmodule
`default_nettype wire

// ===== logic/sync_arm_seq.sv
// Group clock synchroniser and arming sequencer
// Function
// - Sync on command, external input, or trigger line
// - Each sync pulse clears time-tag counters
// - External sync polarity programmable, low after reset
// - Trigger lines 1-7 selectable, 8 disables
// - Sync resets dividers even while sampling
// - Active external sync inhibits all sampling clocks
// - Sync command acts at once, one pulse
// - Initiate arms listed groups, default group 1
// - Immediate initiate stops after post-trigger count
// - Delayed initiate arms triggers after 16 ms steps
// - Continuous runs until stop, records stop address
// - Four checks fail: error, no arming
// - Set spans, relays, wait 16 ms settle
// - Zero-on-arm clears group memory first
// - Load registers, route channels, program slopes
// - Clear measurement-complete bits before enabling
// - Enable, delay, arm triggers, software trigger
`timescale 1ns/1ns
`default_nettype none
`include "sync_arm_regs.svh"
module sync_arm_seq #(
  // Cycles per 16 ms step; a bench may shorten it to keep runs brief
  parameter int STEP_CYC = `SA_STEP_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_ext_sync,
  input wire logic [7:0] i_ttl_trig,
  input wire sync_arm_pkg::grp_t i_post_done,
  input wire sync_arm_pkg::grp_t i_group_active,
  input wire logic [15:0] i_stop_addr,
  output logic o_sync_pulse,
  output logic o_timetag_clr,
  output sync_arm_pkg::grp_t o_div_reset,
  output logic o_clk_inhibit,
  output sync_arm_pkg::grp_t o_set_span,
  output sync_arm_pkg::grp_t o_mem_zero,
  output sync_arm_pkg::grp_t o_load_regs,
  output sync_arm_pkg::grp_t o_route,
  output sync_arm_pkg::grp_t o_prog_slopes,
  output sync_arm_pkg::grp_t o_clr_meas,
  output sync_arm_pkg::grp_t o_acq_en,
  output logic o_ext_arm_en,
  output sync_arm_pkg::grp_t o_trig_arm,
  output sync_arm_pkg::grp_t o_sw_trig,
  output logic o_init_error
);
  import sync_arm_pkg::*;

  // ==========================================================
  // Check word bits: overrun change, routed, fits, threshold
  localparam int CHK_N = 4;

  // Group mask default when software lists none
  function automatic grp_t grp_sel(input grp_t g);
    grp_sel = (g == 4'h0) ? `SA_GRP_DEFAULT : g;
  endfunction

  // Pulse a mask for exactly one state
  function automatic grp_t in_state(input arm_state_e s, input arm_state_e t,
                                    input grp_t g);
    in_state = (s == t) ? g : 4'h0;
  endfunction

  // ==========================================================
  // Whole state in one struct
  typedef struct packed {
    logic level;           // External sync active level
    logic [3:0] ttl_sel;   // Trigger line select, 8 off
    logic sync_pulse;      // Internal sync line
    arm_state_e state;     // Arming sequence
    grp_t grp;             // Groups being armed
    grp_t zero;            // Zero-on-arm mask
    init_mode_e mode;      // Initiate flavour
    logic ext_arm;         // External arm wanted
    logic [31:0] dly;      // Delay in 16 ms steps
    logic [CHK_N-1:0] chk; // Check results, 1 = pass
    grp_t acq;             // Acquisition enabled
    grp_t armed;           // Triggers armed
    grp_t cont;            // Free-running groups
    grp_t stop_ev;         // Stop requests, one cycle
    grp_t swt;             // Software trigger, one cycle
    logic err;             // Last initiate failed
    logic [15:0] trig_addr; // Stop location (read at 0x18)
    logic [31:0] rdata;    // Read data register
  } state_s;
  state_s st_q;
  state_s st_d;

  // ==========================================================
  // Synchronised inputs
  logic ext_sync_s;
  logic [7:0] ttl_s;
  logic tmr_start;
  logic [31:0] tmr_steps;
  logic tmr_busy;
  logic tmr_done;
  logic ext_active;
  logic ttl_active;

  level_sync #(.W(9)) u_in_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_async({i_ext_sync, i_ttl_trig}),
    .o_sync({ext_sync_s, ttl_s})
  );

  // Shared timer for relay settle and start delay
  step_timer #(.STEP_CYC(STEP_CYC)) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_start(tmr_start),
    .i_steps(tmr_steps),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // ==========================================================
  // Sync source decode
  always_comb begin
    ext_active = (ext_sync_s == st_q.level);
    // only lines 1-7 count; 0 never, 8 off
    ttl_active = (st_q.ttl_sel >= 4'h1) && (st_q.ttl_sel <= 4'h7) &&
                 ttl_s[st_q.ttl_sel[2:0]];
  end

  // Timer kicks happen on entry to settle and delay steps
  always_comb begin
    tmr_start = 1'b0;
    tmr_steps = 32'h0;
    if (st_q.state == ST_RANGE && !tmr_busy && !tmr_done &&
        st_d.state == ST_RANGE) begin
      tmr_start = 1'b1;
      tmr_steps = 32'h1;
    end else if (st_q.state == ST_ENABLE) begin
      tmr_start = 1'b1;
      // only a delayed initiate waits; others arm at once
      tmr_steps = (st_q.mode == MODE_DELAY) ? st_q.dly : 32'h0;
    end
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_d = st_q;
    st_d.stop_ev = 4'h0;
    st_d.swt = 4'h0;
    st_d.sync_pulse = i_wr && (i_addr == `SA_SYNC_OFF) && i_wdata[0];
    // Register writes
    if (i_wr) begin
      unique case (i_addr)
        `SA_CTRL_OFF: begin
          st_d.level = i_wdata[`SA_CTRL_LEVEL_BIT];
          // reject line 0 and anything past 8
          if (i_wdata[`SA_CTRL_TTL_MSB:`SA_CTRL_TTL_LSB] != 4'h0 &&
              i_wdata[`SA_CTRL_TTL_MSB:`SA_CTRL_TTL_LSB] <= `SA_TTL_OFF) begin
            st_d.ttl_sel = i_wdata[`SA_CTRL_TTL_MSB:`SA_CTRL_TTL_LSB];
          end
        end
        `SA_CHECK_OFF: st_d.chk = i_wdata[CHK_N-1:0];
        `SA_DLY_OFF: st_d.dly = i_wdata;
        `SA_STOP_OFF: st_d.stop_ev = i_wdata[3:0];
        `SA_INIT_OFF: begin
          // Initiate only from idle; busy writes ignored
          if (st_q.state == ST_IDLE) begin
            st_d.grp = grp_sel(i_wdata[`SA_INIT_GRP_MSB:`SA_INIT_GRP_LSB]);
            st_d.mode = init_mode_e'(
              i_wdata[`SA_INIT_MODE_MSB:`SA_INIT_MODE_LSB]);
            st_d.zero = i_wdata[`SA_INIT_ZERO_MSB:`SA_INIT_ZERO_LSB];
            st_d.ext_arm = i_wdata[`SA_INIT_EXTARM_BIT];
            st_d.state = ST_CHECK;
          end
        end
        default: ;
      endcase
    end
    // immediate or delayed stops on post-trigger count
    // Clears act before the sequencer so a same-cycle set wins
    st_d.acq = st_q.acq & ~(i_post_done & ~st_q.cont) & ~st_q.stop_ev;
    st_d.armed = st_q.armed & ~(i_post_done & ~st_q.cont) & ~st_q.stop_ev;
    // continuous stops only on request; capture address
    st_d.cont = st_q.cont & ~st_q.stop_ev;
    if ((st_q.stop_ev & st_q.cont) != 4'h0) begin
      st_d.trig_addr = i_stop_addr;
    end
    // Sequencer
    unique case (st_q.state)
      ST_IDLE: ;
      ST_CHECK: begin
        // any failed check aborts with error
        st_d.err = (st_q.chk != {CHK_N{1'b1}});
        st_d.state = (st_q.chk == {CHK_N{1'b1}}) ? ST_RANGE : ST_IDLE;
      end
      // spans and relays, then 16 ms settle
      ST_RANGE: if (tmr_done) st_d.state = ST_ZERO;
      ST_ZERO: st_d.state = ST_LOAD;
      ST_LOAD: st_d.state = ST_SETUP;
      ST_SETUP: st_d.state = ST_CLRMC;
      ST_CLRMC: st_d.state = ST_ENABLE;
      ST_ENABLE: begin
        st_d.acq = st_d.acq | st_q.grp;
        if (st_q.mode == MODE_CONT) st_d.cont = st_d.cont | st_q.grp;
        st_d.state = ST_DELAY;
      end
      ST_DELAY: if (tmr_done) st_d.state = ST_ARMTRG;
      ST_ARMTRG: begin
        st_d.armed = st_d.armed | st_q.grp;
        // Software trigger lands as the triggers stand armed
        st_d.swt = st_q.grp;
        st_d.state = ST_IDLE;
      end
      default: st_d.state = ST_IDLE;
    endcase
    // Read data, valid the cycle after the strobe
    st_d.rdata = 32'h0;
    if (i_rd) begin
      unique case (i_addr)
        `SA_CTRL_OFF: st_d.rdata = {24'h0, st_q.ttl_sel, 3'h0, st_q.level};
        `SA_CHECK_OFF: st_d.rdata = {28'h0, st_q.chk};
        `SA_DLY_OFF: st_d.rdata = st_q.dly;
        `SA_STATUS_OFF: st_d.rdata = {9'h0, st_q.err, st_q.cont,
                                      st_q.armed, st_q.acq, st_q.state};
        `SA_ADDR_OFF: st_d.rdata = {16'h0, st_q.trig_addr};
        default: st_d.rdata = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st_q <= '0;
      st_q.level <= `SA_LEVEL_RST;
      st_q.ttl_sel <= `SA_TTL_RST;
      st_q.state <= ST_IDLE;
      st_q.grp <= `SA_GRP_DEFAULT;
      st_q.mode <= MODE_IMM;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  // OR of three sources
  assign o_sync_pulse = st_q.sync_pulse | ext_active | ttl_active;
  // time tags cleared by every sync
  assign o_timetag_clr = o_sync_pulse;
  assign o_div_reset = {4{o_sync_pulse}};
  assign o_clk_inhibit = ext_active;
  assign o_set_span = in_state(st_q.state, ST_RANGE, st_q.grp);
  assign o_mem_zero = in_state(st_q.state, ST_ZERO, st_q.grp & st_q.zero);
  assign o_load_regs = in_state(st_q.state, ST_LOAD, st_q.grp);
  assign o_route = in_state(st_q.state, ST_LOAD, st_q.grp);
  assign o_prog_slopes = in_state(st_q.state, ST_SETUP, st_q.grp);
  assign o_clr_meas = in_state(st_q.state, ST_CLRMC, st_q.grp);
  assign o_acq_en = st_q.acq;
  assign o_ext_arm_en = st_q.ext_arm && (st_q.acq != 4'h0);
  assign o_trig_arm = st_q.armed;
  assign o_sw_trig = st_q.swt;
  assign o_init_error = st_q.err;
  assign o_rdata = st_q.rdata;

  // ==========================================================
  // Checks
  sequence init_write_s;
    i_wr && i_addr == `SA_INIT_OFF && st_q.state == ST_IDLE;
  endsequence

  sync_or_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (st_q.sync_pulse || ttl_active) |-> o_sync_pulse && o_timetag_clr)
    else $error("sync source without sync pulse");
  ttl_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    st_q.ttl_sel == 4'h0 || st_q.ttl_sel == 4'h8 |-> !ttl_active)
    else $error("disabled trigger line drove sync");
  gate_level_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (ext_sync_s == st_q.level) |-> o_clk_inhibit)
    else $error("clocks not inhibited");
  check_fail_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (st_q.state == ST_CHECK && st_q.chk != 4'hf) |=> st_q.state == ST_IDLE
      && o_init_error)
    else $error("failed check still armed");
  zero_order_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    st_q.state == ST_ZERO |=> st_q.state == ST_LOAD ##1 st_q.state == ST_SETUP)
    else $error("zero not before load");
  clr_enable_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    o_clr_meas != 4'h0 |=> st_q.state == ST_ENABLE ##1 (o_acq_en != 4'h0))
    else $error("clear not before enable");
  default_grp_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    init_write_s and i_wdata[3:0] == 4'h0 |=> st_q.grp == 4'h1)
    else $error("default group not 1");
  arm_trig_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    st_q.state == ST_ARMTRG |-> !tmr_busy ##1
      (o_sw_trig == st_q.grp && (o_trig_arm & st_q.grp) == st_q.grp))
    else $error("software trigger out of order");
endmodule
`default_nettype wire

// ===== test/backplane_model.sv
// Behavioural far side: external sync pin and backplane trigger lines
`timescale 1ns/1ns
`default_nettype none
module backplane_model (
  input wire logic i_sys_clk,
  input wire logic i_ext_req,
  input wire logic [3:0] i_line_req,
  output logic o_ext_sync,
  output logic [7:0] o_ttl_trig
);
  // ==========================================================
  // Line drivers
  // Start with the pin high so low-true sync is idle at power-up
  initial begin
    o_ext_sync = 1'b1;
    o_ttl_trig = 8'h00;
  end
  // Pins move 7 ns after the edge: asynchronous to the design's sampling
  always @(posedge i_sys_clk) begin
    o_ext_sync <= #7 i_ext_req;
    // One line at a time; request 8 or above leaves every line idle
    o_ttl_trig <= #7 (i_line_req < 4'h8) ? (8'h01 << i_line_req) : 8'h00;
  end
endmodule
`default_nettype wire

// ===== test/test_sample_sync_and_arm_sequencer.sv
// Self-checking bench for the sync and arm sequencer
`timescale 1ns/1ns
`default_nettype none
`include "sync_arm_regs.svh"
module test_sample_sync_and_arm_sequencer;
  import sync_arm_pkg::*;
  // ==========================================================
  // Signals
  logic i_sys_clk = 1'b0;
  logic i_rstn, i_wr, i_rd, ext_req, ext_pin;
  logic [7:0] i_addr, ttl_pins;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] line_req;
  grp_t i_post_done, i_group_active, o_div_reset, o_set_span;
  grp_t o_acq_en, o_trig_arm, o_mem_zero, o_load_regs, o_route;
  grp_t o_prog_slopes, o_clr_meas, o_sw_trig;
  logic o_ext_arm_en;
  logic [15:0] addr_seen; // Stop address as the block sampled it
  logic [15:0] i_stop_addr;
  logic o_sync_pulse, o_timetag_clr, o_clk_inhibit, o_init_error;
  int errors = 0;
  int checks_done = 0;
  int seed = 27329;
  localparam int STEP = 40; // Short settle step keeps the run brief
  int m_level, m_ttl; // Reference copy of polarity and line select
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  // 50 MHz clock
  always #10 i_sys_clk = ~i_sys_clk;
  // Informational inputs wander randomly; sync must not care
  always @(posedge i_sys_clk) begin
    i_group_active <= 4'($random(seed));
    i_stop_addr <= 16'($random(seed));
    addr_seen <= i_stop_addr;
  end
  // ==========================================================
  // Instances
  backplane_model bp (.i_sys_clk(i_sys_clk), .i_ext_req(ext_req),
    .i_line_req(line_req), .o_ext_sync(ext_pin), .o_ttl_trig(ttl_pins));
  sync_arm_seq #(.STEP_CYC(STEP)) uut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_ext_sync(ext_pin), .i_ttl_trig(ttl_pins),
    .i_post_done(i_post_done), .i_group_active(i_group_active),
    .i_stop_addr(i_stop_addr), .o_sync_pulse(o_sync_pulse),
    .o_timetag_clr(o_timetag_clr), .o_div_reset(o_div_reset),
    .o_clk_inhibit(o_clk_inhibit), .o_set_span(o_set_span),
    .o_mem_zero(o_mem_zero), .o_load_regs(o_load_regs),
    .o_route(o_route), .o_prog_slopes(o_prog_slopes),
    .o_clr_meas(o_clr_meas), .o_acq_en(o_acq_en),
    .o_ext_arm_en(o_ext_arm_en), .o_trig_arm(o_trig_arm),
    .o_sw_trig(o_sw_trig), .o_init_error(o_init_error));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Reset held 20 cycles; the model returns to its reset view too
  task automatic do_reset();
    @(posedge i_sys_clk);
    i_rstn <= 1'b0;
    repeat (20) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    m_level = 0;
    m_ttl = 8;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // One-cycle write; ttl field 0 or above 8 is refused by the block
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    if (a == `SA_CTRL_OFF) begin
      m_level = int'(d[0]);
      if (d[7:4] >= 4'h1 && d[7:4] <= 4'h8) m_ttl = int'(d[7:4]);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input string what);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp_q.pop_front(), what);
  endtask
  task automatic rd_ctrl();
    exp_q.push_back({24'h0, 4'(m_ttl), 3'h0, 1'(m_level)});
    rd(`SA_CTRL_OFF, "ctrl readback");
  endtask
  // Drive the pins, let the synchronisers settle, compare all sync outputs
  task automatic sync_case(input logic ext, input int line);
    logic act, e;
    @(posedge i_sys_clk);
    ext_req <= ext;
    line_req <= 4'(line);
    wait_cyc(5);
    act = (m_level != 0) ? ext : !ext;
    e = act || (m_ttl >= 1 && m_ttl <= 7 && line == m_ttl);
    chk(32'(o_sync_pulse), 32'(e), "sync pulse");
    chk(32'(o_timetag_clr), 32'(e), "timetag clear");
    chk(32'(o_div_reset), {28'h0, {4{e}}}, "divider reset");
    chk(32'(o_clk_inhibit), 32'(act), "clock inhibit");
  endtask
  // Immediate initiate; collects the span mask over the first cycles
  task automatic initiate(input grp_t grp, input logic [3:0] pass);
    grp_t span, g;
    span = 4'h0;
    g = (grp == 4'h0) ? 4'h1 : grp;
    wr(`SA_CHECK_OFF, {28'h0, pass});
    wr(`SA_INIT_OFF, {28'h0, grp});
    repeat (12) begin
      #1;
      span = span | o_set_span;
      @(posedge i_sys_clk);
    end
    #1;
    chk(32'(span), (pass == 4'hf) ? 32'(g) : 32'h0, "span mask");
    chk(32'(o_init_error), 32'(pass != 4'hf), "init error");
    chk(32'(o_acq_en), 32'h0, "acq before settle");
    chk(32'(o_trig_arm), 32'h0, "arm before settle");
  endtask
  // Full arming run: note the cycle at which each step first shows
  task automatic arm_run(input grp_t g, input logic [1:0] mode,
                         input int dly);
    int at[9];
    grp_t seen[9];
    grp_t v[9];
    int c, d;
    c = 0;
    d = (mode == 2'h1) ? dly : 0;
    foreach (at[k]) begin
      at[k] = 0;
      seen[k] = 4'h0;
    end
    wr(`SA_DLY_OFF, 32'(dly));
    wr(`SA_CHECK_OFF, 32'hf);
    wr(`SA_INIT_OFF, {19'h0, 1'b1, g, 2'h0, mode, g});
    while (at[8] == 0 && c < 300) begin
      @(posedge i_sys_clk);
      #1;
      c++;
      v = '{o_set_span, o_mem_zero, o_load_regs, o_route, o_prog_slopes,
            o_clr_meas, o_acq_en, o_sw_trig, o_trig_arm};
      foreach (v[k]) begin
        if (v[k] != 4'h0 && at[k] == 0) at[k] = c;
        seen[k] = seen[k] | v[k];
      end
    end
    foreach (seen[k]) chk(32'(seen[k]), 32'(g), "step groups");
    chk(32'(at[1] - at[0] >= STEP), 32'h1, "relay settle");
    chk(32'(at[1] < at[2]), 32'h1, "zero first");
    chk(32'(at[2] <= at[3] && at[3] < at[4]), 32'h1, "load order");
    chk(32'(at[5] < at[6]), 32'h1, "clear first");
    c = at[8] - at[6] - d * STEP;
    chk(32'(c >= 0 && c <= 3), 32'h1, "arm delay");
    chk(32'(at[7] >= at[8]), 32'h1, "trigger after arm");
    chk(32'(o_ext_arm_en), 32'h1, "ext arm enable");
    // Post-trigger count ends all but free-running groups
    i_post_done <= g;
    wait_cyc(1);
    i_post_done <= 4'h0;
    chk(32'(o_acq_en), (mode == 2'h2) ? 32'(g) : 32'h0, "count stop");
    chk(32'(o_trig_arm), (mode == 2'h2) ? 32'(g) : 32'h0, "disarm");
    if (mode == 2'h2) begin
      wr(`SA_STOP_OFF, {28'h0, g});
      wait_cyc(1);
      exp_q.push_back({16'h0, addr_seen});
      chk(32'(o_acq_en), 32'h0, "stop request");
      rd(`SA_ADDR_OFF, "stop address");
    end
  endtask
  // ==========================================================
  // Watchdog
  initial begin
    #(20 * 20000);
    errors++;
    $display("watchdog expired at %0t", $time);
    stop_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    i_rstn = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_post_done = 4'h0;
    ext_req = 1'b1;
    line_req = 4'h8;
    do_reset();
    rd_ctrl();
    sync_case(1'b0, 8);
    sync_case(1'b1, 8);
    $display("test reset_state done");
    wr(`SA_CTRL_OFF, 32'h81);
    rd_ctrl();
    sync_case(1'b0, 8);
    sync_case(1'b1, 8);
    sync_case(1'b0, 8);
    $display("test polarity done");
    wr(`SA_SYNC_OFF, 32'h1);
    #1;
    chk(32'(o_sync_pulse), 32'h1, "command pulse");
    chk(32'(o_timetag_clr), 32'h1, "command clear");
    wait_cyc(1);
    chk(32'(o_sync_pulse), 32'h0, "pulse width");
    $display("test sync_command done");
    for (int n = 1; n <= 7; n++) begin
      wr(`SA_CTRL_OFF, {24'h0, 4'(n), 4'h1});
      rd_ctrl();
      sync_case(1'b0, n);
      sync_case(1'b0, (n % 7) + 1);
      sync_case(1'b0, 0);
    end
    wr(`SA_CTRL_OFF, 32'h01);
    rd_ctrl();
    wr(`SA_CTRL_OFF, 32'h91);
    rd_ctrl();
    wr(`SA_CTRL_OFF, 32'h81);
    rd_ctrl();
    sync_case(1'b0, 7);
    exp_q.push_back(32'h0);
    rd(8'hfc, "unmapped read");
    $display("test trigger_lines done");
    // each check fails in turn, then all pass
    for (int i = 0; i < 4; i++) begin
      initiate(4'h0, 4'(4'hf ^ (4'h1 << (3 - i))));
    end
    exp_q.push_back(32'h0040_0001);
    rd(`SA_STATUS_OFF, "status after refusal");
    initiate(4'h0, 4'hf);
    exp_q.push_back(32'h0000_0004);
    rd(`SA_STATUS_OFF, "status settling");
    $display("test initiate_checks done");
    repeat (3) begin
      do_reset();
      initiate(4'($random(seed)) | 4'h2, 4'hf);
    end
    $display("test random_groups done");
    for (int m = 0; m < 3; m++) begin
      do_reset();
      wr(`SA_SYNC_OFF, 32'h1);
      arm_run(4'($random(seed)) | 4'h1, 2'(m), m + 1);
    end
    $display("test arm_sequence done");
    stop_test();
  end
endmodule
`default_nettype wire
